/* logic/exception_priority_control.sv */
// exception vectoring, priority and interrupt control registers
// assumes reset, trap and peripheral requests come from logic on aclk;
// the two request pins and the mode strap are asynchronous
//
// Implementation choice: the AXI4-Lite register port.
module exception_priority_control (
  input wire logic aclk,
  input wire logic aresetn,
  input wire exc_pkg::axil_req_s s_axil_req,
  output exc_pkg::axil_rsp_s s_axil_rsp,
  input wire logic special_mode_n,
  input wire logic i_mask,
  input wire logic x_mask,
  input wire logic por_req,
  input wire logic clkmon_req,
  input wire logic watchdog_req,
  input wire logic illegal_op_req,
  input wire logic sw_trap_req,
  input wire logic nonmaskable_pin_request_n,
  input wire logic ext_request_n,
  input wire logic [exc_pkg::N_MASKABLE-1:1] src_req,
  input wire logic [exc_pkg::N_MASKABLE-1:1] src_en,
  input wire logic vector_ack,
  input wire logic stop_exit_req,
  output logic exc_valid,
  output logic [15:0] exc_vector,
  output logic stop_resume
);
  import exc_pkg::*;

  localparam logic [STOP_CNT_W-1:0] STOP_LOAD =
    STOP_CNT_W'(STOP_DELAY_CYCLES - 1);
  localparam logic [ADDR_W-1:0] CTRL_ADDR =
    ADDR_W'({IRQ_CONTROL_IDX, 2'b00});
  localparam logic [ADDR_W-1:0] PRIO_ADDR =
    ADDR_W'({PRIO_ELEVATE_IDX, 2'b00});
  localparam logic [ADDR_W-1:0] STAT_ADDR =
    ADDR_W'({VECTOR_STATUS_IDX, 2'b00});
  // slot 0 is the external pin; bad codes fall back to it
  localparam logic [4:0] PIN_SLOT = 5'h00;

  // register picked by a byte address; anything else is unmapped
  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_CTRL = 2'b01,
    SEL_PRIO = 2'b10,
    SEL_STAT = 2'b11
  } reg_sel_e;

  // whole block state in one word, registered on every edge
  typedef struct packed {
    logic [1:0] ext_sync;
    logic [1:0] xpin_sync;
    logic [1:0] mode_sync;
    logic ext_prev;
    logic ext_edge;
    logic mode_normal;
    logic edge_sel;
    logic edge_seen;
    logic pin_conn;
    logic dly_en;
    logic dly_seen;
    logic [7:0] prio;
    logic aw_got;
    logic [ADDR_W-1:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic valid;
    logic [15:0] vector;
    logic stopping;
    logic [STOP_CNT_W-1:0] stop_cnt;
    logic resume;
  } state_s;

  state_s state_r;
  state_s state_nxt;

  // vector of maskable slot k; the address is fixed per slot
  function automatic logic [15:0] slot_vec(input logic [4:0] k);
    logic [7:0] lo;
    lo = MASK_TOP_CODE - {2'b00, k, 1'b0};
    return {VEC_PAGE, lo};
  endfunction : slot_vec

  // unknown, odd, reserved or too high codes fall back to the pin
  function automatic logic [4:0] promo_slot(input logic [7:0] code);
    logic [7:0] diff;
    logic [4:0] slot;
    diff = MASK_TOP_CODE - code;
    slot = PIN_SLOT;
    if (!code[0] && code <= MASK_TOP_CODE && code >= MASK_LOW_CODE &&
        code != RESERVED_CODE) begin
      slot = diff[5:1];
    end
    return slot;
  endfunction : promo_slot

  // only three control bits exist; the rest reads zero
  function automatic logic [31:0] ctrl_word(input state_s s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[EDGE_SEL_BIT] = s.edge_sel;
    w[PIN_CONN_BIT] = s.pin_conn;
    w[DLY_BIT] = s.dly_en;
    return w;
  endfunction : ctrl_word

  function automatic reg_sel_e reg_decode(input logic [ADDR_W-1:0] a);
    reg_sel_e s;
    case (a)
      CTRL_ADDR: s = SEL_CTRL;
      PRIO_ADDR: s = SEL_PRIO;
      STAT_ADDR: s = SEL_STAT;
      default: s = SEL_NONE;
    endcase
    return s;
  endfunction : reg_decode

  logic ext_low;
  logic ext_fall;
  logic ext_pending;
  logic [N_MASKABLE-1:0] pend;
  logic [4:0] promo;
  logic [4:0] best;
  logic best_hit;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic do_write;
  logic [15:0] pick_vec;
  logic pick_hit;

  assign ext_low = !state_r.ext_sync[1];
  // edge taken on the re-timed level, so it lags the pin by the sync
  assign ext_fall = state_r.ext_prev && !state_r.ext_sync[1];
  // level low or latched falling edge, only when connected
  assign ext_pending = state_r.pin_conn &&
    (state_r.edge_sel ? state_r.ext_edge : ext_low);
  // slots 1 and up carry their own local enable; slot 0 is gated by pin_conn
  assign pend = {src_req & src_en, ext_pending};
  assign promo = promo_slot(state_r.prio);

  always_comb begin
    best = 5'h00;
    best_hit = 1'b0;
    // lowest pending slot number is the default winner
    for (int k = N_MASKABLE - 1; k >= 0; k--) begin
      if (pend[k]) begin
        best = 5'(k);
        best_hit = 1'b1;
      end
    end
  end

  always_comb begin
    pick_vec = 16'h0000;
    pick_hit = 1'b1;
    if (por_req) begin
      pick_vec = VEC_RESET;
    end else if (clkmon_req) begin
      pick_vec = VEC_CLKMON;
    end else if (watchdog_req) begin
      pick_vec = VEC_WDOG;
    end else if (illegal_op_req) begin
      pick_vec = VEC_ILLEGAL;
    end else if (sw_trap_req) begin
      pick_vec = VEC_SWTRAP;
      // pin request is a level; the core sets X on entry, so no repeat
    end else if (!x_mask && !state_r.xpin_sync[1]) begin
      pick_vec = VEC_XPIN;
    end else if (!i_mask && best_hit) begin
      // promotion only reorders; every slot keeps its own vector
      if (pend[promo]) begin
        pick_vec = slot_vec(promo);
      end else begin
        pick_vec = slot_vec(best);
      end
    end else begin
      pick_hit = 1'b0;
    end
  end

  // address and data may come in either order; both wait for the answer
  assign aw_take = s_axil_req.awvalid && !state_r.aw_got &&
    !state_r.bvalid;
  assign w_take = s_axil_req.wvalid && !state_r.w_got && !state_r.bvalid;
  // one read in flight; arready falls until the data is taken
  assign ar_take = s_axil_req.arvalid && !state_r.rvalid;
  assign do_write = state_r.aw_got && state_r.w_got && !state_r.bvalid;

  always_comb begin
    state_nxt = state_r;
    state_nxt.ext_sync = {state_r.ext_sync[0], ext_request_n};
    state_nxt.xpin_sync = {state_r.xpin_sync[0],
      nonmaskable_pin_request_n};
    state_nxt.ext_prev = state_r.ext_sync[1];
    // acknowledge of the pin vector drops the latch; a new edge wins
    if (vector_ack && state_r.vector == slot_vec(PIN_SLOT)) begin
      state_nxt.ext_edge = 1'b0;
    end
    if (ext_fall && state_r.pin_conn && state_r.edge_sel) begin
      state_nxt.ext_edge = 1'b1;
    end
    if (!state_r.edge_sel || !state_r.pin_conn) begin
      state_nxt.ext_edge = 1'b0;
    end
    // choice is re-made and registered on every edge
    state_nxt.valid = pick_hit;
    state_nxt.vector = pick_vec;

    if (aw_take) begin
      state_nxt.aw_got = 1'b1;
      state_nxt.awaddr = s_axil_req.awaddr;
    end
    if (w_take) begin
      state_nxt.w_got = 1'b1;
      state_nxt.wdata = s_axil_req.wdata;
      state_nxt.wstrb = s_axil_req.wstrb;
    end
    if (do_write) begin
      state_nxt.aw_got = 1'b0;
      state_nxt.w_got = 1'b0;
      state_nxt.bvalid = 1'b1;
      state_nxt.bresp = RESP_OKAY;
      case (reg_decode(state_r.awaddr))
        SEL_CTRL: begin
          if (state_r.wstrb[0]) begin
            state_nxt.pin_conn = state_r.wdata[PIN_CONN_BIT];
            state_nxt.edge_seen = 1'b1;
            state_nxt.dly_seen = 1'b1;
            // normal: first write only; special: not first
            if (state_r.mode_normal != state_r.edge_seen) begin
              state_nxt.edge_sel = state_r.wdata[EDGE_SEL_BIT];
            end
            // normal: first write only; special: always
            if (!state_r.mode_normal || !state_r.dly_seen) begin
              state_nxt.dly_en = state_r.wdata[DLY_BIT];
            end
          end
        end
        SEL_PRIO: begin
          // writes while I is clear are dropped without an error
          if (state_r.wstrb[0] && i_mask) begin
            state_nxt.prio = state_r.wdata[7:0];
          end
        end
        SEL_STAT: begin
          state_nxt.bresp = RESP_OKAY;
        end
        default: begin
          state_nxt.bresp = RESP_SLVERR;
        end
      endcase
    end
    if (state_r.bvalid && s_axil_req.bready) begin
      state_nxt.bvalid = 1'b0;
    end

    if (state_r.rvalid && s_axil_req.rready) begin
      state_nxt.rvalid = 1'b0;
    end
    if (ar_take) begin
      state_nxt.rvalid = 1'b1;
      state_nxt.rresp = RESP_OKAY;
      case (reg_decode(s_axil_req.araddr))
        SEL_CTRL: begin
          state_nxt.rdata = ctrl_word(state_r);
        end
        SEL_PRIO: begin
          state_nxt.rdata = {24'h00_0000, state_r.prio};
        end
        SEL_STAT: begin
          // snapshot of the vector shown in the cycle of the take
          state_nxt.rdata = 32'h0000_0000;
          state_nxt.rdata[STATUS_VALID_BIT] = state_r.valid;
          state_nxt.rdata[15:0] = state_r.vector;
        end
        default: begin
          state_nxt.rdata = 32'h0000_0000;
          state_nxt.rresp = RESP_SLVERR;
        end
      endcase
    end

    // delay counted on aclk, which stands for the E clock
    state_nxt.resume = 1'b0;
    // a wake while the delay runs is dropped, not queued
    if (state_r.stopping) begin
      if (state_r.stop_cnt == '0) begin
        state_nxt.stopping = 1'b0;
        state_nxt.resume = 1'b1;
      end else begin
        state_nxt.stop_cnt = state_r.stop_cnt - 1'b1;
      end
    end else if (stop_exit_req) begin
      if (state_r.dly_en) begin
        state_nxt.stopping = 1'b1;
        state_nxt.stop_cnt = STOP_LOAD;
      end else begin
        state_nxt.resume = 1'b1;
      end
    end

    if (!aresetn) begin
      state_nxt = '0;
      // pin syncs start at the idle high level so no false edge follows
      state_nxt.ext_sync = 2'h3;
      state_nxt.xpin_sync = 2'h3;
      state_nxt.ext_prev = 1'b1;
      // strap is re-timed by two flops and caught while reset is held
      state_nxt.mode_sync = {state_r.mode_sync[0], special_mode_n};
      state_nxt.mode_normal = state_r.mode_sync[1];
      state_nxt.edge_sel = EDGE_SEL_RST;
      state_nxt.pin_conn = PIN_CONN_RST;
      state_nxt.dly_en = DLY_RST;
      state_nxt.prio = PRIO_RST;
    end
  end

  always_ff @(posedge aclk) begin
    state_r <= state_nxt;
  end

  always_comb begin
    s_axil_rsp = '0;
    // ready falls while an answer waits for its handshake
    s_axil_rsp.awready = !state_r.aw_got && !state_r.bvalid;
    s_axil_rsp.wready = !state_r.w_got && !state_r.bvalid;
    s_axil_rsp.bvalid = state_r.bvalid;
    s_axil_rsp.bresp = state_r.bresp;
    s_axil_rsp.arready = !state_r.rvalid;
    s_axil_rsp.rvalid = state_r.rvalid;
    s_axil_rsp.rdata = state_r.rdata;
    s_axil_rsp.rresp = state_r.rresp;
  end

  assign exc_valid = state_r.valid;
  assign exc_vector = state_r.vector;
  assign stop_resume = state_r.resume;
endmodule : exception_priority_control

/* logic/exc_pkg.sv */
// constants and bus carriers of the exception priority block
// assumes one bus clock and a CPU core that holds the I and X mask flags
package exc_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] IRQ_CONTROL_IDX = 8'h1E;
  localparam logic [7:0] PRIO_ELEVATE_IDX = 8'h1F;
  localparam logic [7:0] VECTOR_STATUS_IDX = 8'h20;
  localparam int unsigned EDGE_SEL_BIT = 7;
  localparam int unsigned PIN_CONN_BIT = 6;
  localparam int unsigned DLY_BIT = 5;
  localparam int unsigned STATUS_VALID_BIT = 16;
  localparam logic EDGE_SEL_RST = 1'b0;
  localparam logic PIN_CONN_RST = 1'b1;
  localparam logic DLY_RST = 1'b1;
  localparam logic [7:0] PRIO_RST = 8'hF2;
  localparam logic [7:0] VEC_PAGE = 8'hFF;
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_CLKMON = 16'hFFFC;
  localparam logic [15:0] VEC_WDOG = 16'hFFFA;
  localparam logic [15:0] VEC_ILLEGAL = 16'hFFF8;
  localparam logic [15:0] VEC_SWTRAP = 16'hFFF6;
  localparam logic [15:0] VEC_XPIN = 16'hFFF4;
  localparam logic [7:0] MASK_TOP_CODE = 8'hF2;
  localparam logic [7:0] MASK_LOW_CODE = 8'hD2;
  localparam logic [7:0] RESERVED_CODE = 8'hD4;
  localparam int unsigned N_MASKABLE = 17;
  localparam int unsigned STOP_DELAY_CYCLES = 4096;
  localparam int unsigned STOP_CNT_W = 12;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } axil_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_s;
endpackage : exc_pkg

/* verification/exception_priority_control_monitor.sv */
// port assertions for the exception priority block
// assumes bind into exception_priority_control
module exception_priority_control_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic i_mask,
  input wire logic x_mask,
  input wire logic por_req,
  input wire logic clkmon_req,
  input wire logic watchdog_req,
  input wire logic illegal_op_req,
  input wire logic sw_trap_req,
  input wire logic [exc_pkg::N_MASKABLE-1:1] src_req,
  input wire logic [exc_pkg::N_MASKABLE-1:1] src_en,
  input wire logic stop_exit_req,
  input wire logic exc_valid,
  input wire logic [15:0] exc_vector,
  input wire logic stop_resume
);
  import exc_pkg::*;
  logic [4:0] nm;
  logic [12:0] since_r;
  assign nm = {por_req, clkmon_req, watchdog_req, illegal_op_req, sw_trap_req};
  // saturates so a stray resume never aliases to a legal count
  always_ff @(posedge aclk) begin
    if (!aresetn) since_r <= '0;
    else if (stop_exit_req) since_r <= 13'h0001;
    else if (since_r != '0 && since_r != 13'h1FFF) since_r <= since_r + 13'h1;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_PAGE: assert property (
    exc_valid |-> exc_vector[15:8] == VEC_PAGE && !exc_vector[0])
    else $error("vector off top page");
  AST_POR: assert property (
    por_req |=> exc_valid && exc_vector == 16'hFFFE) else $error("reset lost");
  AST_CLKMON: assert property (
    nm[4:3] == 2'h1 |=> exc_valid && exc_vector == 16'hFFFC)
    else $error("clock monitor order");
  AST_WDOG: assert property (
    nm[4:2] == 3'h1 |=> exc_valid && exc_vector == 16'hFFFA)
    else $error("watchdog order");
  AST_TRAP: assert property (
    nm[4:1] == 4'h1 |=> exc_valid && exc_vector == 16'hFFF8)
    else $error("opcode trap order");
  AST_SWTRAP: assert property (
    nm == 5'h01 |=> exc_valid && exc_vector == 16'hFFF6)
    else $error("software trap order");
  AST_MASKED: assert property (
    i_mask && x_mask && nm == 5'h00 |=> !exc_valid) else $error("mask leak");
  AST_OPEN: assert property (
    !i_mask && src_req[1] && src_en[1] |=> exc_valid) else $error("no request");
  AST_RESUME: assert property (
    stop_resume |-> since_r == 13'h0001 || since_r == 13'h1001)
    else $error("resume delay");
  AST_PULSE: assert property (
    stop_resume |=> !stop_resume) else $error("resume not a pulse");
  cover property (por_req ##1 exc_valid);
  cover property (stop_resume);
  cover property (exc_vector == 16'hFFD8);
endmodule : exception_priority_control_monitor

bind exception_priority_control exception_priority_control_monitor mon (
  .aclk(aclk), .aresetn(aresetn), .i_mask(i_mask), .x_mask(x_mask),
  .por_req(por_req), .clkmon_req(clkmon_req), .watchdog_req(watchdog_req),
  .illegal_op_req(illegal_op_req), .sw_trap_req(sw_trap_req),
  .src_req(src_req), .src_en(src_en), .stop_exit_req(stop_exit_req),
  .exc_valid(exc_valid), .exc_vector(exc_vector), .stop_resume(stop_resume));

/* verification/cpu_core_model.sv */
// core model: mask flags and vector fetch acknowledge
// assumes the bench asks for flag changes
module cpu_core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic set_i,
  input wire logic set_x,
  input wire logic ack_en,
  input wire logic exc_valid,
  output logic i_mask,
  output logic x_mask,
  output logic vector_ack
);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      i_mask <= 1'b1;
      x_mask <= 1'b1;
      vector_ack <= 1'b0;
    end else begin
      i_mask <= set_i; // bench raises it before elevate writes except the one meant to be dropped
      x_mask <= set_x;
      vector_ack <= ack_en && exc_valid && !vector_ack;
    end
  end
endmodule : cpu_core_model

/* verification/tb_top.sv */
// bench for the exception priority block
// assumes core model beside it; drives at rising edges
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import exc_pkg::*;
  logic aclk = 0, aresetn = 0, smode_n = 1, set_i = 1, set_x = 1, ack_en = 0;
  logic i_m, x_m, v_ack, valid, resume, xpin_n = 1, ext_n = 1, stop_req = 0;
  logic [4:0] nm = '0;
  logic [16:1] sreq = '0, sen = '0;
  logic [15:0] vec;
  axil_req_s req = '0;
  axil_rsp_s rsp;
  int err_total = 0, num_checks = 0;
  always #4 aclk = ~aclk;
  exception_priority_control dut (.aclk(aclk), .aresetn(aresetn),
    .s_axil_req(req), .s_axil_rsp(rsp), .special_mode_n(smode_n),
    .i_mask(i_m), .x_mask(x_m), .por_req(nm[4]), .clkmon_req(nm[3]),
    .watchdog_req(nm[2]), .illegal_op_req(nm[1]), .sw_trap_req(nm[0]),
    .nonmaskable_pin_request_n(xpin_n), .ext_request_n(ext_n),
    .src_req(sreq), .src_en(sen), .vector_ack(v_ack), .stop_exit_req(stop_req),
    .exc_valid(valid), .exc_vector(vec), .stop_resume(resume));
  cpu_core_model core (.aclk(aclk), .aresetn(aresetn), .set_i(set_i),
    .set_x(set_x), .ack_en(ack_en), .exc_valid(valid), .i_mask(i_m),
    .x_mask(x_m), .vector_ack(v_ack));
  task automatic fail(input string m);
    err_total++;
    $display("[ERR] %0t %s", $time, m);
  endtask : fail
  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) fail("register data");
  endtask : chk32
  // zero expected means nothing presented
  task automatic chkv(input logic [15:0] e);
    num_checks++;
    if (vec !== e || valid !== (e != 16'h0000)) fail("vector");
  endtask : chkv
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    req.awvalid <= 1;
    req.awaddr <= a;
    req.wvalid <= 1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.bready <= 1;
    forever begin
      @(posedge aclk);
      if (req.awvalid && rsp.awready) req.awvalid <= 0;
      if (req.wvalid && rsp.wready) req.wvalid <= 0;
      if (rsp.bvalid) break;
    end
    req.bready <= 0;
    chk32({30'h0, rsp.bresp}, {30'h0, RESP_OKAY});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    @(posedge aclk);
    req.araddr <= a;
    req.arvalid <= 1;
    req.rready <= 1;
    forever begin
      @(posedge aclk);
      if (req.arvalid && rsp.arready) req.arvalid <= 0;
      if (rsp.rvalid) break;
    end
    req.rready <= 0;
    chk32(rsp.rdata, e);
    chk32({30'h0, rsp.rresp}, {30'h0, er});
  endtask : rd
  task automatic stop_wait(input int e);
    int n;
    @(posedge aclk);
    stop_req <= 1;
    @(posedge aclk);
    stop_req <= 0;
    for (n = 1; n < 5000; n++) begin
      @(posedge aclk);
      if (resume === 1'b1) break;
    end
    num_checks++;
    if (n != e) fail("resume delay");
  endtask : stop_wait
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize
  // whole run is near 4300 cycles
  initial begin
    #200000;
    fail("watchdog expired");
    summarize();
  end
  initial begin
    tick(20);
    aresetn <= 1;
    rd(8'h78, 32'h60, RESP_OKAY);
    rd(8'h7C, 32'hF2, RESP_OKAY);
    rd(8'h40, 32'h0, RESP_SLVERR);
    stop_wait(4097);
    $display("reset values and stop delay done");
    for (int k = 0; k < 5; k++) begin
      nm <= 5'h1F >> k;
      tick(3);
      chkv(16'hFFFE - 16'(2 * k));
    end
    nm <= '0;
    xpin_n <= 0;
    set_x <= 0;
    tick(6);
    chkv(16'hFFF4);
    set_x <= 1;
    tick(4);
    chkv(16'h0000);
    xpin_n <= 1;
    set_i <= 0;
    sreq <= '1;
    sen <= '1;
    tick(5);
    chkv(16'hFFF0);
    set_i <= 1;
    tick(4);
    chkv(16'h0000);
    wr(8'h7C, 32'hD8);
    set_i <= 0;
    tick(4);
    chkv(16'hFFD8);
    sen[13] <= 0;
    tick(3);
    chkv(16'hFFF0);
    sen[13] <= 1;
    wr(8'h7C, 32'hDA);
    tick(3);
    chkv(16'hFFD8);
    set_i <= 1;
    tick(3);
    wr(8'h7C, 32'hDA);
    set_i <= 0;
    tick(4);
    chkv(16'hFFDA);
    set_i <= 1;
    tick(3);
    wr(8'h7C, 32'hD4);
    rd(8'h7C, 32'hD4, RESP_OKAY);
    set_i <= 0;
    tick(4);
    chkv(16'hFFF0);
    ext_n <= 0;
    tick(6);
    chkv(16'hFFF2);
    rd(8'h80, 32'h0001_FFF2, RESP_OKAY);
    $display("priority and promotion done");
    wr(8'h78, 32'h3F);
    tick(4);
    chkv(16'hFFF0);
    rd(8'h78, 32'h20, RESP_OKAY);
    wr(8'h78, 32'hE0);
    rd(8'h78, 32'h60, RESP_OKAY);
    tick(4);
    chkv(16'hFFF2);
    $display("normal mode control done");
    aresetn <= 0;
    smode_n <= 0;
    ext_n <= 1;
    sreq <= '0;
    set_i <= 1;
    tick(20);
    aresetn <= 1;
    wr(8'h78, 32'hC0);
    wr(8'h78, 32'hC0);
    rd(8'h78, 32'hC0, RESP_OKAY);
    stop_wait(1);
    set_i <= 0;
    ext_n <= 0;
    tick(2);
    ext_n <= 1;
    tick(6);
    chkv(16'hFFF2);
    ack_en <= 1;
    tick(4);
    ack_en <= 0;
    chkv(16'h0000);
    $display("special mode and edge sense done");
    summarize();
  end
endmodule : tb_top
